// ---- hdl/crt_device.sv ----
/*
  Device end: allocates tracker entries, issues requests, collects
  responses and data, answers pulls and reports completions.
  Assumes the host keeps its side of the link protocol.
*/
//
// Contract
// - Data header tag routes data to entry
// - Half select picks lower/upper 32 bytes
// - Poisoned data is never consumed
// - Error data neither cached nor snoop-served
// - Hold a credit before any request
// - Read gets optional observe plus line
// - Read entry held until all messages
// - Full line buffer reserved at issue
// - Device may stall incoming data
// - Observe accepted anywhere among data
// - Read0 completes on response, no data
// - Host pull never after observe-invalid
// - Posted merged; non-posted pull first
// - Observe-invalid ends store; evict drops ownership
// - Pull answered with exactly 64 bytes
// - Write done after observe and data
// - Host write done after data, observe
// - Read0-write: merged message, data, done
// - Read opcodes 00001 to 00100
// - Read0 opcodes 00101, 01000 and 10000
// - Read0-write opcodes 00110 and 00111
// - Writes and evictions; clean eviction 01001
`timescale 1ns/1ps
module crt_device
  import crt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  crt_link_if.device lnk,
  input wire logic req_valid,
  input wire logic [OP_W-1:0] req_opcode,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [LINE_W-1:0] req_wdata,
  input wire logic [BE_W-1:0] req_be,
  output logic req_ready,
  output logic [TAG_W-1:0] req_tag,
  input wire logic drain_stall,
  output logic rd_done_valid,
  output logic [TAG_W-1:0] rd_done_tag,
  output logic [LINE_W-1:0] rd_done_data,
  output logic rd_done_poison,
  output logic rd_done_cacheable,
  output logic wr_done_valid,
  output logic [TAG_W-1:0] wr_done_tag,
  output logic observe_valid,
  output logic [TAG_W-1:0] observe_tag,
  output logic relinquish
);
  typedef struct packed {
    logic busy;
    crt_sem_e sem;
    logic [OP_W-1:0] op;
    logic lo;
    logic hi;
    logic rsp;
    logic goi;
    logic pull;
    logic sent;
    logic poison;
    logic err;
    logic [LINE_W-1:0] line;
    logic [BE_W-1:0] be;
  } crt_dev_ent_s;

  typedef struct packed {
    crt_dev_ent_s [ENTRIES-1:0] ent;
    logic [3:0] credits;
    logic req_ready;
    logic [TAG_W-1:0] req_tag;
    logic q_valid;
    logic [OP_W-1:0] q_op;
    logic [TAG_W-1:0] q_tag;
    logic [ADDR_W-1:0] q_addr;
    logic data_ready;
    logic d_valid;
    logic [TAG_W-1:0] d_tag;
    logic [LINE_W-1:0] d_line;
    logic [BE_W-1:0] d_be;
    logic rd_valid;
    logic [TAG_W-1:0] rd_tag;
    logic [LINE_W-1:0] rd_line;
    logic rd_poison;
    logic rd_cacheable;
    logic wr_valid;
    logic [TAG_W-1:0] wr_tag;
    logic ob_valid;
    logic [TAG_W-1:0] ob_tag;
    logic relinq;
  } crt_dev_s;

  crt_dev_s q;
  crt_dev_s d;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic found;
    logic done;
    logic [IDX_W-1:0] idx;
    crt_dhdr_s hdr;
    d = q;
    found = 1'b0;
    done = 1'b0;
    idx = '0;
    hdr = lnk.h2d_data_hdr;
    d.q_valid = 1'b0;
    d.d_valid = 1'b0;
    d.rd_valid = 1'b0;
    d.wr_valid = 1'b0;
    d.ob_valid = 1'b0;
    d.relinq = 1'b0;
    if (lnk.h2d_credit) begin
      d.credits = q.credits + 4'h1;
    end
    // Issue into the lowest free entry; ready already implied a credit
    if (q.req_ready && req_valid) begin
      for (int i = ENTRIES - 1; i >= 0; i--) begin
        if (!q.ent[i].busy) begin
          idx = IDX_W'(i);
        end
      end
      d.credits = d.credits - 4'h1;
      d.ent[idx] = '0;
      d.ent[idx].busy = 1'b1;
      d.ent[idx].op = req_opcode;
      d.ent[idx].sem = crt_sem(req_opcode);
      d.ent[idx].line = req_wdata;
      d.ent[idx].be = req_be;
      d.q_valid = 1'b1;
      d.q_op = req_opcode;
      d.q_tag = TAG_W'(idx);
      d.q_addr = req_addr;
    end
    // Responses, in any order relative to data
    if (lnk.h2d_rsp_valid && lnk.h2d_rsp_tag < TAG_W'(ENTRIES)) begin
      idx = lnk.h2d_rsp_tag[IDX_W-1:0];
      if (q.ent[idx].busy) begin
        d.ent[idx].rsp = 1'b1;
        if (lnk.h2d_rsp_opcode == RSP_GO_ERR) begin
          d.ent[idx].err = 1'b1;
        end
        if (lnk.h2d_rsp_opcode == RSP_PULL || lnk.h2d_rsp_opcode == RSP_GO_I_PULL) begin
          d.ent[idx].pull = 1'b1;
        end
        if (lnk.h2d_rsp_opcode == RSP_GO_I || lnk.h2d_rsp_opcode == RSP_GO_I_PULL) begin
          d.ent[idx].goi = 1'b1;
          d.ob_valid = 1'b1;
          d.ob_tag = lnk.h2d_rsp_tag;
          d.relinq = crt_evict(q.ent[idx].op);
        end
      end
    end
    // Incoming read data, accepted only while ready
    if (lnk.h2d_data_valid && q.data_ready && hdr.device_entry_tag < TAG_W'(ENTRIES)) begin
      idx = hdr.device_entry_tag[IDX_W-1:0];
      if (q.ent[idx].busy && q.ent[idx].sem == SEM_READ) begin
        if (lnk.h2d_data_full) begin
          d.ent[idx].line = lnk.h2d_data_payload;
          d.ent[idx].lo = 1'b1;
          d.ent[idx].hi = 1'b1;
        end else if (hdr.half_line_select) begin
          d.ent[idx].line[LINE_W-1:HALF_W] = lnk.h2d_data_payload[HALF_W-1:0];
          d.ent[idx].hi = 1'b1;
        end else begin
          d.ent[idx].line[HALF_W-1:0] = lnk.h2d_data_payload[HALF_W-1:0];
          d.ent[idx].lo = 1'b1;
        end
        d.ent[idx].poison = q.ent[idx].poison | hdr.poison;
        d.ent[idx].err = d.ent[idx].err | hdr.go_err;
      end
    end
    // One full-line data message per pulled entry
    for (int i = 0; i < ENTRIES; i++) begin
      if (!found && q.ent[i].busy && q.ent[i].pull && !q.ent[i].sent) begin
        found = 1'b1;
        d.ent[i].sent = 1'b1;
        d.d_valid = 1'b1;
        d.d_tag = TAG_W'(i);
        d.d_line = q.ent[i].line;
        d.d_be = q.ent[i].be;
      end
    end
    // Release the lowest entry whose completion condition holds
    for (int i = 0; i < ENTRIES; i++) begin
      if (!done && q.ent[i].busy) begin
        case (q.ent[i].sem)
          SEM_READ: begin
            if (q.ent[i].lo && q.ent[i].hi && (q.ent[i].rsp || q.ent[i].op == OP_CUR_READ)) begin
              done = 1'b1;
              d.rd_valid = 1'b1;
              d.rd_tag = TAG_W'(i);
              d.rd_line = q.ent[i].poison ? '0 : q.ent[i].line;
              d.rd_poison = q.ent[i].poison;
              d.rd_cacheable = !q.ent[i].err && q.ent[i].op != OP_CUR_READ;
            end
          end
          SEM_READ0: begin
            if (q.ent[i].rsp) begin
              done = 1'b1;
              d.wr_valid = 1'b1;
              d.wr_tag = TAG_W'(i);
            end
          end
          default: begin
            if (q.ent[i].goi && q.ent[i].sent) begin
              done = 1'b1;
              d.wr_valid = 1'b1;
              d.wr_tag = TAG_W'(i);
            end
          end
        endcase
        if (done) begin
          d.ent[i].busy = 1'b0;
        end
      end
    end
    // Ready only with a credit and a free entry left
    d.req_ready = 1'b0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (!d.ent[i].busy && d.credits != 4'h0) begin
        d.req_ready = !(q.req_ready && req_valid);
        d.req_tag = TAG_W'(i);
      end
    end
    d.data_ready = !drain_stall;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.credits <= CREDIT_INIT;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign req_ready = q.req_ready;
  assign req_tag = q.req_tag;
  assign lnk.d2h_req_valid = q.q_valid;
  assign lnk.d2h_req_opcode = q.q_op;
  assign lnk.d2h_req_tag = q.q_tag;
  assign lnk.d2h_req_addr = q.q_addr;
  assign lnk.h2d_data_ready = q.data_ready;
  assign lnk.d2h_data_valid = q.d_valid;
  assign lnk.d2h_data_tag = q.d_tag;
  assign lnk.d2h_data_payload = q.d_line;
  assign lnk.d2h_data_be = q.d_be;
  assign rd_done_valid = q.rd_valid;
  assign rd_done_tag = q.rd_tag;
  assign rd_done_data = q.rd_line;
  assign rd_done_poison = q.rd_poison;
  assign rd_done_cacheable = q.rd_cacheable;
  assign wr_done_valid = q.wr_valid;
  assign wr_done_tag = q.wr_tag;
  assign observe_valid = q.ob_valid;
  assign observe_tag = q.ob_tag;
  assign relinquish = q.relinq;
endmodule

// ---- hdl/crt_host.sv ----
/*
  Host end: serves one device request at a time with responses,
  data and pulls, and returns the credit when the request is done.
  Assumes the device holds a credit per request.
*/
`timescale 1ns/1ps
module crt_host
  import crt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  crt_link_if.host lnk,
  input wire logic [LINE_W-1:0] host_line,
  input wire logic split_mode,
  input wire logic posted_mode,
  input wire logic err_mode,
  input wire logic poison_mode,
  output logic wr_valid,
  output logic [TAG_W-1:0] wr_tag,
  output logic [LINE_W-1:0] wr_data,
  output logic [BE_W-1:0] wr_be
);
  typedef enum logic [6:0] {
    H_IDLE = 7'h01, H_DAT0 = 7'h02, H_RSP = 7'h04, H_DAT1 = 7'h08,
    H_WAIT = 7'h10, H_GOI = 7'h20, H_DONE = 7'h40
  } crt_host_e;

  typedef struct packed {
    crt_host_e st;
    logic [OP_W-1:0] op;
    logic [TAG_W-1:0] tag;
    logic split;
    logic need_goi;
    logic [LINE_W-1:0] line;
    logic credit;
    logic r_valid;
    logic [RSP_W-1:0] r_op;
    logic dv;
    crt_dhdr_s hdr;
    logic full;
    logic [LINE_W-1:0] pay;
    logic w_valid;
    logic [TAG_W-1:0] w_tag;
    logic [LINE_W-1:0] w_data;
    logic [BE_W-1:0] w_be;
  } crt_host_s;

  crt_host_s q;
  crt_host_s d;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic taken;
    d = q;
    taken = q.dv && lnk.h2d_data_ready;
    d.credit = 1'b0;
    d.r_valid = 1'b0;
    d.w_valid = 1'b0;
    case (q.st)
      H_IDLE: begin
        if (lnk.d2h_req_valid) begin
          d.op = lnk.d2h_req_opcode;
          d.tag = lnk.d2h_req_tag;
          d.split = split_mode;
          d.line = host_line;
          d.hdr = '0;
          d.hdr.valid = 1'b1;
          d.hdr.device_entry_tag = lnk.d2h_req_tag;
          d.hdr.poison = poison_mode;
          d.hdr.go_err = err_mode;
          d.r_op = RSP_GO_I_PULL;
          d.need_goi = 1'b0;
          case (crt_sem(lnk.d2h_req_opcode))
            SEM_READ: begin
              d.dv = 1'b1;
              d.full = !split_mode;
              d.pay = split_mode ? {{HALF_W{1'b0}}, host_line[HALF_W-1:0]} : host_line;
              d.st = H_DAT0;
            end
            SEM_READ0: begin
              d.st = H_RSP;
            end
            SEM_R0W: begin
              d.r_valid = 1'b1;
              d.st = H_WAIT;
            end
            default: begin
              d.r_valid = 1'b1;
              d.r_op = posted_mode ? RSP_GO_I_PULL : RSP_PULL;
              d.need_goi = !posted_mode;
              d.st = H_WAIT;
            end
          endcase
        end
      end
      H_DAT0: begin
        if (taken) begin
          d.dv = 1'b0;
          if (q.op != OP_CUR_READ) begin
            d.st = H_RSP;
          end else if (q.split) begin
            d.st = H_DAT1;
          end else begin
            d.st = H_DONE;
          end
        end
      end
      H_RSP: begin
        d.r_valid = 1'b1;
        d.r_op = err_mode ? RSP_GO_ERR : RSP_GO;
        d.st = (crt_sem(q.op) == SEM_READ && q.split) ? H_DAT1 : H_DONE;
      end
      H_DAT1: begin
        d.dv = !taken;
        d.hdr.half_line_select = 1'b1;
        d.pay = {{HALF_W{1'b0}}, q.line[LINE_W-1:HALF_W]};
        if (q.dv && taken) begin
          d.st = H_DONE;
        end
      end
      H_WAIT: begin
        if (lnk.d2h_data_valid && lnk.d2h_data_tag == q.tag) begin
          d.w_valid = 1'b1;
          d.w_tag = q.tag;
          d.w_data = lnk.d2h_data_payload;
          d.w_be = lnk.d2h_data_be;
          d.st = q.need_goi ? H_GOI : H_DONE;
        end
      end
      H_GOI: begin
        d.r_valid = 1'b1;
        d.r_op = RSP_GO_I;
        d.st = H_DONE;
      end
      H_DONE: begin
        d.credit = 1'b1;
        d.st = H_IDLE;
      end
      default: begin
        d.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.st <= H_IDLE;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign lnk.h2d_credit = q.credit;
  assign lnk.h2d_rsp_valid = q.r_valid;
  assign lnk.h2d_rsp_opcode = q.r_op;
  assign lnk.h2d_rsp_tag = q.tag;
  assign lnk.h2d_data_valid = q.dv;
  assign lnk.h2d_data_hdr = q.hdr;
  assign lnk.h2d_data_full = q.full;
  assign lnk.h2d_data_payload = q.pay;
  assign wr_valid = q.w_valid;
  assign wr_tag = q.w_tag;
  assign wr_data = q.w_data;
  assign wr_be = q.w_be;
endmodule

// ---- hdl/crt_link_if.sv ----
/*
  Link between device tracker and host coherence agent.
  Assumes both ends run on sys_clk; no clocking block.
*/
`timescale 1ns/1ps
interface crt_link_if;
  import crt_pkg::*;
  logic d2h_req_valid;
  logic [OP_W-1:0] d2h_req_opcode;
  logic [TAG_W-1:0] d2h_req_tag;
  logic [ADDR_W-1:0] d2h_req_addr;
  logic h2d_credit;
  logic h2d_rsp_valid;
  logic [RSP_W-1:0] h2d_rsp_opcode;
  logic [TAG_W-1:0] h2d_rsp_tag;
  logic h2d_data_valid;
  crt_dhdr_s h2d_data_hdr;
  logic h2d_data_full;
  logic [LINE_W-1:0] h2d_data_payload;
  logic h2d_data_ready;
  logic d2h_data_valid;
  logic [TAG_W-1:0] d2h_data_tag;
  logic [LINE_W-1:0] d2h_data_payload;
  logic [BE_W-1:0] d2h_data_be;

  modport device (
    output d2h_req_valid, d2h_req_opcode, d2h_req_tag, d2h_req_addr,
    input h2d_credit, h2d_rsp_valid, h2d_rsp_opcode, h2d_rsp_tag,
    input h2d_data_valid, h2d_data_hdr, h2d_data_full, h2d_data_payload,
    output h2d_data_ready, d2h_data_valid, d2h_data_tag, d2h_data_payload, d2h_data_be
  );
  modport host (
    input d2h_req_valid, d2h_req_opcode, d2h_req_tag, d2h_req_addr,
    output h2d_credit, h2d_rsp_valid, h2d_rsp_opcode, h2d_rsp_tag,
    output h2d_data_valid, h2d_data_hdr, h2d_data_full, h2d_data_payload,
    input h2d_data_ready, d2h_data_valid, d2h_data_tag, d2h_data_payload, d2h_data_be
  );
endinterface

// ---- hdl/crt_pkg.sv ----
/*
  Shared constants, header layout and opcode decode for the coherent
  request tracker. Assumes both link ends share one clock and reset.
*/
package crt_pkg;
  localparam int TAG_W = 12;
  localparam int OP_W = 5;
  localparam int RSP_W = 4;
  localparam int LINE_W = 512;
  localparam int HALF_W = 256;
  localparam int BE_W = 64;
  localparam int ADDR_W = 46;
  localparam int ENTRIES = 4;
  localparam int IDX_W = 2;
  localparam logic [3:0] CREDIT_INIT = 4'h1;

  // Device request opcodes
  localparam logic [4:0] OP_CUR_READ = 5'h01;
  localparam logic [4:0] OP_OWN_READ = 5'h02;
  localparam logic [4:0] OP_SHARED_READ = 5'h03;
  localparam logic [4:0] OP_ANY_READ = 5'h04;
  localparam logic [4:0] OP_OWN_NO_PAYLOAD = 5'h05;
  localparam logic [4:0] OP_FULL_OWN_WRITE = 5'h06;
  localparam logic [4:0] OP_MEM_FULL_WRITE = 5'h07;
  localparam logic [4:0] OP_LINE_INVAL = 5'h08;
  localparam logic [4:0] OP_CLEAN_EVICT = 5'h09;
  localparam logic [4:0] OP_DIRTY_EVICT = 5'h0a;
  localparam logic [4:0] OP_CLEAN_EVICT_NODATA = 5'h0b;
  localparam logic [4:0] OP_LAST_WRITE = 5'h0e;
  localparam logic [4:0] OP_CACHE_FLUSHED = 5'h10;

  // Host response opcodes
  localparam logic [3:0] RSP_GO = 4'h1;
  localparam logic [3:0] RSP_GO_ERR = 4'h2;
  localparam logic [3:0] RSP_PULL = 4'h3;
  localparam logic [3:0] RSP_GO_I = 4'h4;
  localparam logic [3:0] RSP_GO_I_PULL = 4'h5;

  // Host-to-device data header, 24 bits
  typedef struct packed {
    logic valid;
    logic [TAG_W-1:0] device_entry_tag;
    logic half_line_select;
    logic poison;
    logic go_err;
    logic [7:0] rsvd;
  } crt_dhdr_s;

  typedef enum logic [1:0] {SEM_READ, SEM_READ0, SEM_R0W, SEM_WRITE} crt_sem_e;

  function automatic crt_sem_e crt_sem(input logic [OP_W-1:0] op);
    if (op >= OP_CUR_READ && op <= OP_ANY_READ) begin
      return SEM_READ;
    end else if (op == OP_FULL_OWN_WRITE || op == OP_MEM_FULL_WRITE) begin
      return SEM_R0W;
    end else if (op >= OP_CLEAN_EVICT && op <= OP_LAST_WRITE) begin
      return SEM_WRITE;
    end else begin
      return SEM_READ0;
    end
  endfunction

  function automatic logic crt_evict(input logic [OP_W-1:0] op);
    return op >= OP_CLEAN_EVICT && op <= OP_CLEAN_EVICT_NODATA;
  endfunction
endpackage

// ---- test/coherent_request_tracker_bench.sv ----
/*
  Self-checking bench: device and host ends joined by the link,
  driven from both user sides. Assumes one request in flight at a time.
*/
`timescale 1ns/1ps
module coherent_request_tracker_bench
  import crt_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  logic [OP_W-1:0] req_opcode = '0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [LINE_W-1:0] req_wdata = '0, host_line = '0;
  logic [BE_W-1:0] req_be = '0;
  logic drain_stall = 1'b0, split_mode = 1'b0, posted_mode = 1'b0, err_mode = 1'b0, poison_mode = 1'b0;
  logic req_ready, rd_done_valid, rd_done_poison, rd_done_cacheable, wr_done_valid, observe_valid, relinquish, wr_valid;
  logic [TAG_W-1:0] req_tag, rd_done_tag, wr_done_tag, observe_tag, wr_tag, got_tag, got_otag, got_wtag;
  logic [LINE_W-1:0] rd_done_data, wr_data, got_line;
  logic [BE_W-1:0] wr_be, got_be;
  logic [1:0] got_bits;
  int fails = 0, comparisons = 0, cycles = 0;
  int t_rd, t_wd, t_obs, t_wv, t_rel;

  always #10 sys_clk = ~sys_clk;

  crt_link_if lnk ();
  crt_device crt_device_i (.sys_clk(sys_clk), .reset(reset), .lnk(lnk), .req_valid(req_valid),
    .req_opcode(req_opcode), .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be), .req_ready(req_ready),
    .req_tag(req_tag), .drain_stall(drain_stall), .rd_done_valid(rd_done_valid), .rd_done_tag(rd_done_tag),
    .rd_done_data(rd_done_data), .rd_done_poison(rd_done_poison), .rd_done_cacheable(rd_done_cacheable),
    .wr_done_valid(wr_done_valid), .wr_done_tag(wr_done_tag), .observe_valid(observe_valid),
    .observe_tag(observe_tag), .relinquish(relinquish));
  crt_host crt_host_i (.sys_clk(sys_clk), .reset(reset), .lnk(lnk), .host_line(host_line),
    .split_mode(split_mode), .posted_mode(posted_mode), .err_mode(err_mode), .poison_mode(poison_mode),
    .wr_valid(wr_valid), .wr_tag(wr_tag), .wr_data(wr_data), .wr_be(wr_be));
  crt_link_properties crt_link_properties_i (.sys_clk(sys_clk), .reset(reset),
    .d2h_req_valid(lnk.d2h_req_valid), .d2h_req_opcode(lnk.d2h_req_opcode), .d2h_req_tag(lnk.d2h_req_tag),
    .h2d_credit(lnk.h2d_credit), .h2d_rsp_valid(lnk.h2d_rsp_valid), .h2d_rsp_opcode(lnk.h2d_rsp_opcode),
    .h2d_rsp_tag(lnk.h2d_rsp_tag), .h2d_data_valid(lnk.h2d_data_valid), .h2d_data_hdr(lnk.h2d_data_hdr),
    .h2d_data_ready(lnk.h2d_data_ready), .d2h_data_valid(lnk.d2h_data_valid), .d2h_data_tag(lnk.d2h_data_tag));

  ////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [LINE_W-1:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Issue one request, then record when each completion event shows
  task automatic run(input logic [OP_W-1:0] op, input int stall);
    int n;
    t_rd = -1;
    t_wd = -1;
    t_obs = -1;
    t_wv = -1;
    t_rel = -1;
    drain_stall = stall > 0;
    req_opcode = op;
    req_addr = ADDR_W'({op, 6'h0});
    for (n = 0; n < 80 && req_ready !== 1'b1; n++) @(posedge sys_clk) #1;
    chk("req_tag", LINE_W'(12'h000), LINE_W'(req_tag));
    req_valid = 1'b1;
    @(posedge sys_clk) #1;
    req_valid = 1'b0;
    chk("req_msg", LINE_W'({op, 1'b1, 12'h000, req_addr}), LINE_W'({lnk.d2h_req_opcode, lnk.d2h_req_valid, lnk.d2h_req_tag, lnk.d2h_req_addr}));
    for (n = 1; n < 60 && t_rd < 0 && t_wd < 0; n++) begin
      @(posedge sys_clk) #1;
      if (n == stall) drain_stall = 1'b0;
      if (rd_done_valid === 1'b1) begin
        t_rd = n;
        got_tag = rd_done_tag;
        got_line = rd_done_data;
        got_bits = {rd_done_poison, rd_done_cacheable};
      end
      if (wr_done_valid === 1'b1) begin
        t_wd = n;
        got_tag = wr_done_tag;
      end
      if (observe_valid === 1'b1) begin
        t_obs = n;
        got_otag = observe_tag;
      end
      if (relinquish === 1'b1) t_rel = n;
      if (wr_valid === 1'b1) begin
        t_wv = n;
        got_wtag = wr_tag;
        got_line = wr_data;
        got_be = wr_be;
      end
    end
    drain_stall = 1'b0;
  endtask

  ////////////////////////////////////////
  task automatic t_read(input logic [OP_W-1:0] op, input logic split, poison, err, input int stall);
    host_line = {{8{27'h35ac3e1, op}}, {8{27'h1b2d4f0, op}}};
    split_mode = split;
    poison_mode = poison;
    err_mode = err;
    run(op, stall);
    chk("rd_done_late", LINE_W'(1'b1), LINE_W'(t_rd > stall));
    chk("rd_tag", LINE_W'(12'h000), LINE_W'(got_tag));
    chk("rd_data", poison ? {LINE_W{1'b0}} : host_line, got_line);
    chk("rd_flags", LINE_W'({poison, !err && op != OP_CUR_READ}), LINE_W'(got_bits));
  endtask

  task automatic t_read0(input logic [OP_W-1:0] op);
    run(op, 0);
    chk("r0_done", LINE_W'(13'h1000), LINE_W'({t_wd > 0, got_tag}));
    chk("r0_no_data", LINE_W'(1'b1), LINE_W'(t_rd < 0 && t_wv < 0));
  endtask

  task automatic t_write(input logic [OP_W-1:0] op, input logic posted);
    logic r0w, evict;
    r0w = op == OP_FULL_OWN_WRITE || op == OP_MEM_FULL_WRITE;
    evict = op >= OP_CLEAN_EVICT && op <= OP_CLEAN_EVICT_NODATA;
    req_wdata = {16{27'h2c9e071, op}};
    req_be = {8{op, 3'h5}};
    posted_mode = posted;
    err_mode = 1'b0;
    poison_mode = 1'b0;
    run(op, 0);
    chk("wr_data", req_wdata, got_line);
    chk("wr_be", LINE_W'(req_be), LINE_W'(got_be));
    chk("wr_done_tag", LINE_W'(12'h000), LINE_W'(got_tag));
    chk("wr_side_tags", LINE_W'(24'h000000), LINE_W'({got_otag, got_wtag}));
    chk("wr_done_last", LINE_W'(1'b1), LINE_W'(t_obs > 0 && t_wv > 0 && t_wd >= t_obs && t_wd >= t_wv));
    chk("observe_first", LINE_W'(posted || r0w), LINE_W'(t_obs < t_wv));
    chk("relinquish", LINE_W'(evict), LINE_W'(t_rel == t_obs));
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge sys_clk);
    #1 reset = 1'b0;
    t_read(OP_CUR_READ, 1'b0, 1'b0, 1'b0, 0);
    t_read(OP_OWN_READ, 1'b1, 1'b0, 1'b0, 6);
    t_read(OP_SHARED_READ, 1'b1, 1'b1, 1'b0, 0);
    t_read(OP_ANY_READ, 1'b0, 1'b0, 1'b1, 3);
    t_read0(OP_OWN_NO_PAYLOAD);
    t_read0(OP_LINE_INVAL);
    t_read0(OP_CACHE_FLUSHED);
    t_write(OP_FULL_OWN_WRITE, 1'b0);
    t_write(OP_MEM_FULL_WRITE, 1'b1);
    t_write(OP_CLEAN_EVICT, 1'b1);
    t_write(OP_CLEAN_EVICT, 1'b0);
    t_write(OP_DIRTY_EVICT, 1'b0);
    t_write(OP_LAST_WRITE, 1'b1);
    tally_and_finish();
  end
endmodule

// ---- test/crt_link_properties.sv ----
/*
  Concurrent checks on the link between the two tracker ends.
  Assumes one request in flight at a time (a single host credit).
*/
`timescale 1ns/1ps
module crt_link_properties
  import crt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic d2h_req_valid,
  input wire logic [OP_W-1:0] d2h_req_opcode,
  input wire logic [TAG_W-1:0] d2h_req_tag,
  input wire logic h2d_credit,
  input wire logic h2d_rsp_valid,
  input wire logic [RSP_W-1:0] h2d_rsp_opcode,
  input wire logic [TAG_W-1:0] h2d_rsp_tag,
  input wire logic h2d_data_valid,
  input wire crt_dhdr_s h2d_data_hdr,
  input wire logic h2d_data_ready,
  input wire logic d2h_data_valid,
  input wire logic [TAG_W-1:0] d2h_data_tag
);
  ////////////////////////////////////////
  // Tracking of the request in flight
  logic [3:0] credits_q;
  logic [TAG_W-1:0] tag_q;
  logic read0_q, r0w_q, pulled_q;
  logic [1:0] gos_q;
  wire pull = h2d_rsp_valid && (h2d_rsp_opcode == RSP_PULL || h2d_rsp_opcode == RSP_GO_I_PULL);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      credits_q <= CREDIT_INIT;
      tag_q <= '0;
      read0_q <= 1'b0;
      r0w_q <= 1'b0;
      pulled_q <= 1'b0;
      gos_q <= 2'h0;
    end else begin
      credits_q <= credits_q + {3'h0, h2d_credit} - {3'h0, d2h_req_valid};
      if (d2h_req_valid) begin
        tag_q <= d2h_req_tag;
        read0_q <= d2h_req_opcode == 5'h05 || d2h_req_opcode == 5'h08 || d2h_req_opcode == 5'h10;
        r0w_q <= d2h_req_opcode == 5'h06 || d2h_req_opcode == 5'h07;
        pulled_q <= 1'b0;
        gos_q <= 2'h0;
      end else begin
        if (pull) pulled_q <= 1'b1;
        if (h2d_rsp_valid && (h2d_rsp_opcode == RSP_GO || h2d_rsp_opcode == RSP_GO_ERR)) gos_q <= gos_q + 2'h1;
      end
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  credit_held_a: assert property (d2h_req_valid |-> credits_q != 4'h0)
    else $error("request sent without a credit");
  hdr_tag_a: assert property (h2d_data_valid |-> h2d_data_hdr.valid && h2d_data_hdr.device_entry_tag == tag_q)
    else $error("data header tag does not match entry");
  data_hold_a: assert property (h2d_data_valid && !h2d_data_ready |=> h2d_data_valid && $stable(h2d_data_hdr))
    else $error("refused data not held");
  read0_nodata_a: assert property (read0_q |-> !h2d_data_valid)
    else $error("data sent for a response-only request");
  pull_first_a: assert property (h2d_rsp_valid && h2d_rsp_opcode == RSP_GO_I |-> pulled_q)
    else $error("observe sent before data pull");
  r0w_merged_a: assert property (h2d_rsp_valid && r0w_q |-> h2d_rsp_opcode == RSP_GO_I_PULL)
    else $error("merged response not used");
  pull_answer_a: assert property (pull |-> ##2 d2h_data_valid && d2h_data_tag == $past(h2d_rsp_tag, 2))
    else $error("pull not answered two cycles later");
  data_cause_a: assert property (d2h_data_valid |-> $past(pull, 2))
    else $error("data sent without a pull");
  go_once_a: assert property (gos_q <= 2'h1)
    else $error("more than one observe for a read");
  rsp_tag_a: assert property (h2d_rsp_valid |-> h2d_rsp_tag == tag_q)
    else $error("response tag does not match entry");

  cover property (pull && h2d_rsp_opcode == RSP_GO_I_PULL);
  cover property (h2d_data_valid && !h2d_data_ready);
  cover property (h2d_rsp_valid && h2d_rsp_opcode == RSP_GO_I && pulled_q);
endmodule
